//--- hdl/pmtc_defines.svh
// Offsets, field positions and timing counts of the
// power-mode trip control block. Included by every file that uses its macros.
`ifndef PMTC_DEFINES_SVH
`define PMTC_DEFINES_SVH

// Byte addresses seen through the SMBus register engine
`define A_IPOS_LO     8'h60
`define A_INEG_LO     8'h64
`define A_PACK_VOLTAGE_LO    8'h68
`define A_VCELL_LO    8'h6C
`define A_STORE_LO    8'h70
`define A_TRIPCTL     8'h76
`define A_OPERATION_MODE_CONTROL      8'h7A
`define A_CAL_FIRST   8'h80
`define A_CAL_LAST    8'h84

// Nonvolatile initialization image sweep
`define NV_FIRST      9'h020
`define NV_LAST       9'h084

// Trip enable control fields
`define TE_IEX        7
`define TE_IENT       6
`define TE_PACK_VOLTAGE_EXIT_ENABLE       5
`define TE_C1ENT      4
`define TE_C2ENT      3
`define TE_STORAGE_ENTRY_ENABLE      2
`define TE_OVF        0
`define TE_RW_MASK    8'hFC

// Operation mode control fields
`define OM_SAMPLE_SLEEP_ENABLE       7
`define OM_DIV_HI     5
`define OM_DIV_LO     3
`define OM_SHELF      2
`define OM_PORF       1
`define OM_SOFT       0

// Conversion input selects
`define SEL_CURRENT   3'h0
`define SEL_PACK      3'h3
`define SEL_CELL1     3'h4
`define SEL_CELL2     3'h5

// Timing
`define CLK_PERIOD_NS 5
`define SAMPLE_BASE_MS 500
`define SAMPLE_BASE_CYC (`SAMPLE_BASE_MS * 1000000 / `CLK_PERIOD_NS)

`endif

//--- hdl/pmtc_pkg.sv
// Types shared by the power-mode trip control design.
// Assumes the constants header is included by each user.
package pmtc_pkg;
  typedef enum logic [1:0] {
    ST_HOLD,
    ST_LOAD,
    ST_RUN,
    ST_SHELF
  } pm_state_t;
endpackage : pmtc_pkg

//--- hdl/nv_image_loader.sv
// Sweeps the nonvolatile initialization image and emits one write per byte.
// Assumes a memory whose data is valid the cycle after address and read.
`timescale 1ns/1ps
`include "pmtc_defines.svh"
module nv_image_loader (
  // Clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_srst,
  // Control
  input  wire logic       i_start,
  output logic            o_done,
  // Nonvolatile memory
  output logic [8:0]      o_nv_addr,
  output logic            o_nv_rd,
  input  wire logic [7:0] i_nv_data,
  // Register write stream
  output logic            o_wr,
  output logic [7:0]      o_wr_addr,
  output logic [7:0]      o_wr_data
);
  logic       pend_r;
  logic [8:0] pend_addr_r;

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_nv_rd   <= 1'b0;
      o_nv_addr <= `NV_FIRST;
    end else if (i_start) begin
      o_nv_rd   <= 1'b1;
      o_nv_addr <= `NV_FIRST;
    end else if (o_nv_rd) begin
      if (o_nv_addr == `NV_LAST) begin
        o_nv_rd <= 1'b0;
      end else begin
        o_nv_addr <= o_nv_addr + 9'h001;
      end
    end
  end

  // Data arrives one cycle behind the address, so the write lags by two
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      pend_r      <= 1'b0;
      pend_addr_r <= 9'h000;
      o_wr        <= 1'b0;
      o_wr_addr   <= 8'h00;
      o_wr_data   <= 8'h00;
      o_done      <= 1'b0;
    end else begin
      pend_r      <= o_nv_rd & ~i_start;
      pend_addr_r <= o_nv_addr;
      o_wr        <= pend_r;
      o_wr_addr   <= pend_addr_r[7:0];
      o_wr_data   <= i_nv_data;
      o_done      <= pend_r && (pend_addr_r == `NV_LAST);
    end
  end
endmodule : nv_image_loader

//--- hdl/power_mode_trip_control.sv
// Power-mode control: trip thresholds, operation mode, power-on sequence.
// Assumes an SMBus register engine in front (byte read/write port), a
// converter delivering results on the same clock, and async bus pins.
`timescale 1ns/1ps
`include "pmtc_defines.svh"

module power_mode_trip_control
  import pmtc_pkg::*;
#(
  parameter int unsigned HALF_SEC_CYC = `SAMPLE_BASE_CYC
) (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_srst,
  // Supply monitor and SMBus pins (asynchronous)
  input  wire logic        i_cell1_above_por,
  input  wire logic        i_sda_in,
  input  wire logic        i_scl_in,
  // Register port from the SMBus engine
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic        i_reg_wr,
  input  wire logic [7:0]  i_reg_wdata,
  output logic [7:0]       o_reg_rdata,
  // Conversion results
  input  wire logic        i_result_valid,
  input  wire logic [2:0]  i_result_sel,
  input  wire logic [2:0]  i_result_res,
  input  wire logic [15:0] i_result_data,
  input  wire logic        i_result_ovf,
  input  wire logic [2:0]  i_sample_div,
  // Nonvolatile image
  output logic [8:0]       o_nv_addr,
  output logic             o_nv_rd,
  input  wire logic [7:0]  i_nv_data,
  // Initialization writes for the other working registers
  output logic             o_init_wr,
  output logic [7:0]       o_init_addr,
  output logic [7:0]       o_init_data,
  // Mode outputs
  output logic             o_run,
  output logic             o_sample_sleep,
  output logic             o_shelf_sleep,
  output logic             o_conv_start,
  output logic [39:0]      o_cal_trim
);
  localparam logic [26:0] BASE_LAST = 27'(HALF_SEC_CYC - 1);

  pm_state_t   st_r;
  logic [15:0] thr_r [0:4];
  logic [7:0]  cal_r [0:4];
  logic [7:0]  trip_en_r;
  logic        ovf_r;
  logic        sample_sleep_enable_r;
  logic [2:0]  sdiv_r;
  logic        shelf_arm_r;
  logic        stop_seen_r;
  logic        por_flag_r;
  logic        power_on_r;
  logic        ld_start_r;
  logic        ld_done;
  logic        ld_wr;
  logic [7:0]  ld_addr;
  logic [7:0]  ld_data;
  logic [1:0]  por_sync_r;
  logic [1:0]  sda_sync_r;
  logic [1:0]  scl_sync_r;
  logic        sda_q_r;
  logic [26:0] base_cnt_r;
  logic [14:0] ival_cnt_r;
  logic        por_ok;
  logic        host_wr;
  logic        stop_det;
  logic        bus_low;
  logic [14:0] res_mag;
  logic        exit_c;
  logic        enter_c;
  logic        store_c;

  // Magnitude with the sign dropped and bits below resolution zeroed
  function automatic logic [14:0] mag(input logic [15:0] v,
                                      input logic [2:0]  res);
    logic [14:0] keep;
    keep = 15'h7FFF << (3'h7 - res);
    return v[14:0] & keep;
  endfunction : mag

  // Threshold index for a byte address, 7 when not a threshold byte
  function automatic logic [2:0] thr_idx(input logic [7:0] a);
    logic [2:0] idx;
    idx = 3'h7;
    if (a[1] == 1'b0 && a >= `A_IPOS_LO && a < `A_STORE_LO + 8'h02) begin
      idx = 3'((a - `A_IPOS_LO) >> 2);
    end
    return idx;
  endfunction : thr_idx

  nv_image_loader u_loader (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_start   (ld_start_r),
    .o_done    (ld_done),
    .o_nv_addr (o_nv_addr),
    .o_nv_rd   (o_nv_rd),
    .i_nv_data (i_nv_data),
    .o_wr      (ld_wr),
    .o_wr_addr (ld_addr),
    .o_wr_data (ld_data)
  );

  assign o_init_wr   = ld_wr;
  assign o_init_addr = ld_addr;
  assign o_init_data = ld_data;
  assign o_cal_trim  = {cal_r[4], cal_r[3], cal_r[2], cal_r[1], cal_r[0]};
  assign o_sample_sleep = sample_sleep_enable_r;

  // Pins pass two flops; the edge detector reads only the second
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      por_sync_r <= 2'b00;
      sda_sync_r <= 2'b11;
      scl_sync_r <= 2'b11;
      sda_q_r    <= 1'b1;
    end else begin
      por_sync_r <= {por_sync_r[0], i_cell1_above_por};
      sda_sync_r <= {sda_sync_r[0], i_sda_in};
      scl_sync_r <= {scl_sync_r[0], i_scl_in};
      sda_q_r    <= sda_sync_r[1];
    end
  end

  assign por_ok   = por_sync_r[1];
  assign stop_det = scl_sync_r[1] & sda_sync_r[1] & ~sda_q_r;
  assign bus_low  = ~scl_sync_r[1] & ~sda_sync_r[1];
  assign host_wr  = i_reg_wr && (st_r == ST_RUN);

  // Trip evaluation on each result update
  assign res_mag = mag(i_result_data, i_result_res);
  always_comb begin
    exit_c  = 1'b0;
    enter_c = 1'b0;
    store_c = 1'b0;
    if (i_result_valid && st_r == ST_RUN) begin
      case (i_result_sel)
        `SEL_CURRENT: begin
          exit_c  = trip_en_r[`TE_IEX] &&
                    res_mag > mag(thr_r[0], i_result_res);
          enter_c = trip_en_r[`TE_IENT] &&
                    res_mag < mag(thr_r[1], i_result_res);
        end
        `SEL_PACK: begin
          exit_c  = trip_en_r[`TE_PACK_VOLTAGE_EXIT_ENABLE] &&
                    res_mag > mag(thr_r[2], i_result_res);
          store_c = trip_en_r[`TE_STORAGE_ENTRY_ENABLE] &&
                    res_mag < mag(thr_r[4], i_result_res);
        end
        `SEL_CELL1: begin
          enter_c = trip_en_r[`TE_C1ENT] &&
                    res_mag < mag(thr_r[3], i_result_res);
        end
        `SEL_CELL2: begin
          enter_c = trip_en_r[`TE_C2ENT] &&
                    res_mag < mag(thr_r[3], i_result_res);
        end
        default: begin
          exit_c  = 1'b0;
        end
      endcase
    end
  end

  // Power sequence: a supply loss drops back to hold from any state
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      st_r       <= ST_HOLD;
      ld_start_r <= 1'b0;
      power_on_r <= 1'b0;
    end else begin
      ld_start_r <= 1'b0;
      if (!por_ok) begin
        st_r <= ST_HOLD;
      end else begin
        case (st_r)
          ST_HOLD: begin
            st_r       <= ST_LOAD;
            ld_start_r <= 1'b1;
            power_on_r <= 1'b1;
          end
          ST_LOAD: begin
            if (ld_done) begin
              st_r       <= ST_RUN;
              power_on_r <= 1'b0;
            end
          end
          ST_RUN: begin
            if (host_wr && i_reg_addr == `A_OPERATION_MODE_CONTROL &&
                i_reg_wdata[`OM_SOFT]) begin
              st_r       <= ST_LOAD;
              ld_start_r <= 1'b1;
            end else if (store_c ||
                         (shelf_arm_r && stop_seen_r && bus_low)) begin
              st_r <= ST_SHELF;
            end
          end
          ST_SHELF: begin
            st_r <= ST_SHELF;
          end
          default: begin
            st_r <= ST_HOLD;
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_run         <= 1'b0;
      o_shelf_sleep <= 1'b0;
    end else begin
      o_run         <= (st_r == ST_RUN);
      o_shelf_sleep <= (st_r == ST_SHELF);
    end
  end

  // Threshold registers, written by the image load or the host
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      for (int i = 0; i < 5; i++) begin
        thr_r[i] <= 16'h0000;
      end
    end else if (ld_wr && thr_idx(ld_addr) != 3'h7) begin
      if (ld_addr[0]) begin
        thr_r[thr_idx(ld_addr)][15:8] <= ld_data;
      end else begin
        thr_r[thr_idx(ld_addr)][7:0]  <= ld_data;
      end
    end else if (host_wr && thr_idx(i_reg_addr) != 3'h7) begin
      if (i_reg_addr[0]) begin
        thr_r[thr_idx(i_reg_addr)][15:8] <= i_reg_wdata;
      end else begin
        thr_r[thr_idx(i_reg_addr)][7:0]  <= i_reg_wdata;
      end
    end
  end

  // Calibration trim loaded from the image; host writes are not blocked
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      for (int i = 0; i < 5; i++) begin
        cal_r[i] <= 8'h00;
      end
    end else if (ld_wr && ld_addr >= `A_CAL_FIRST) begin
      cal_r[3'(ld_addr - `A_CAL_FIRST)] <= ld_data;
    end else if (host_wr && i_reg_addr >= `A_CAL_FIRST &&
                 i_reg_addr <= `A_CAL_LAST) begin
      cal_r[3'(i_reg_addr - `A_CAL_FIRST)] <= i_reg_wdata;
    end
  end

  // Trip enables; overflow set wins over a clearing write
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      trip_en_r <= 8'h00;
      ovf_r     <= 1'b0;
    end else begin
      if (ld_wr && ld_addr == `A_TRIPCTL) begin
        trip_en_r <= ld_data & `TE_RW_MASK;
        ovf_r     <= ld_data[`TE_OVF];
      end else if (host_wr && i_reg_addr == `A_TRIPCTL) begin
        trip_en_r <= i_reg_wdata & `TE_RW_MASK;
        ovf_r     <= i_reg_wdata[`TE_OVF];
      end
      if (i_result_valid && i_result_ovf) begin
        ovf_r <= 1'b1;
      end
    end
  end

  // Operation mode: trip events override a same-cycle host write
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      sample_sleep_enable_r      <= 1'b0;
      sdiv_r      <= 3'h0;
      shelf_arm_r <= 1'b0;
    end else begin
      if (ld_wr && ld_addr == `A_OPERATION_MODE_CONTROL) begin
        sample_sleep_enable_r      <= ld_data[`OM_SAMPLE_SLEEP_ENABLE];
        sdiv_r      <= ld_data[`OM_DIV_HI:`OM_DIV_LO];
        shelf_arm_r <= ld_data[`OM_SHELF];
      end else if (host_wr && i_reg_addr == `A_OPERATION_MODE_CONTROL) begin
        sample_sleep_enable_r <= i_reg_wdata[`OM_SAMPLE_SLEEP_ENABLE];
        sdiv_r <= i_reg_wdata[`OM_DIV_HI:`OM_DIV_LO];
        if (i_reg_wdata[`OM_SHELF]) begin
          shelf_arm_r <= 1'b1;
        end
      end
      if (exit_c) begin
        sample_sleep_enable_r <= 1'b0;
      end else if (enter_c) begin
        sample_sleep_enable_r <= 1'b1;
      end
      if (st_r == ST_HOLD) begin
        shelf_arm_r <= 1'b0;
      end
    end
  end

  // A Stop seen after arming, then both lines low, completes the request
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      stop_seen_r <= 1'b0;
    end else if (!shelf_arm_r) begin
      stop_seen_r <= 1'b0;
    end else if (stop_det) begin
      stop_seen_r <= 1'b1;
    end
  end

  // Power-on flag: the end of a power-on load wins over a host clear
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      por_flag_r <= 1'b0;
    end else if (st_r == ST_LOAD && ld_done && power_on_r) begin
      por_flag_r <= 1'b1;
    end else if (host_wr && i_reg_addr == `A_OPERATION_MODE_CONTROL &&
                 !i_reg_wdata[`OM_PORF]) begin
      por_flag_r <= 1'b0;
    end
  end

  // Sample-sleep conversion interval, counted only while sleeping
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || !sample_sleep_enable_r || st_r != ST_RUN) begin
      base_cnt_r   <= 27'h0000000;
      ival_cnt_r   <= 15'h0000;
      o_conv_start <= 1'b0;
    end else begin
      o_conv_start <= 1'b0;
      if (base_cnt_r == BASE_LAST) begin
        base_cnt_r <= 27'h0000000;
        if (ival_cnt_r >= (15'h0001 << ({1'b0, i_sample_div} +
                                        {1'b0, sdiv_r})) - 15'h0001) begin
          ival_cnt_r   <= 15'h0000;
          o_conv_start <= 1'b1;
        end else begin
          ival_cnt_r <= ival_cnt_r + 15'h0001;
        end
      end else begin
        base_cnt_r <= base_cnt_r + 27'h0000001;
      end
    end
  end

  // Read data, one cycle after the address; unmapped bytes read zero
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_reg_rdata <= 8'h00;
    end else if (thr_idx(i_reg_addr) != 3'h7) begin
      o_reg_rdata <= i_reg_addr[0] ? thr_r[thr_idx(i_reg_addr)][15:8]
                                   : thr_r[thr_idx(i_reg_addr)][7:0];
    end else if (i_reg_addr == `A_TRIPCTL) begin
      o_reg_rdata <= trip_en_r | {7'h00, ovf_r};
    end else if (i_reg_addr == `A_OPERATION_MODE_CONTROL) begin
      o_reg_rdata <= {sample_sleep_enable_r, 1'b0, sdiv_r, shelf_arm_r,
                      por_flag_r, 1'b0};
    end else if (i_reg_addr >= `A_CAL_FIRST &&
                 i_reg_addr <= `A_CAL_LAST) begin
      o_reg_rdata <= cal_r[3'(i_reg_addr - `A_CAL_FIRST)];
    end else begin
      o_reg_rdata <= 8'h00;
    end
  end

  a_entry_trip: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (enter_c && !exit_c) |=> sample_sleep_enable_r)
    else $error("enabled entry trip did not set sample-sleep");
  a_exit_trip: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    exit_c |=> !sample_sleep_enable_r)
    else $error("enabled exit trip did not clear sample-sleep");
  a_trip_gated: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (i_result_valid && trip_en_r == 8'h00 && !host_wr && !ld_wr)
      |=> $stable(sample_sleep_enable_r))
    else $error("disabled trip changed sample-sleep");
  a_ovf_sticky: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (i_result_valid && i_result_ovf) |=> (ovf_r ##1 (o_reg_rdata[0]
      || $past(i_reg_addr) != `A_TRIPCTL)))
    else $error("overflow flag not set");
  a_soft_reload: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (host_wr && i_reg_addr == `A_OPERATION_MODE_CONTROL && i_reg_wdata[`OM_SOFT] && por_ok)
      |=> (st_r == ST_LOAD && ld_start_r) ##3 o_init_wr)
    else $error("soft re-init did not reload");
  a_por_flag: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (st_r == ST_LOAD && ld_done && power_on_r) |=> por_flag_r)
    else $error("power-on flag not set");
  a_shelf_defer: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (st_r == ST_RUN && !store_c && !(stop_seen_r && bus_low))
      |=> st_r != ST_SHELF)
    else $error("storage-sleep entered without bus idle low");
  a_hold_supply: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    !por_ok |=> (st_r == ST_HOLD) ##1 !o_run)
    else $error("not held while supply low");
  a_reserved_zero: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    ($past(i_reg_addr) == `A_OPERATION_MODE_CONTROL && !$past(i_srst))
      |-> (o_reg_rdata[6] == 1'b0 && o_reg_rdata[0] == 1'b0))
    else $error("reserved mode bit read nonzero");
endmodule : power_mode_trip_control

//--- tb/nv_image_model.sv
// Nonvolatile image model standing at the block's memory port.
// Assumes a registered address and read strobe; data follows one cycle later.
`timescale 1ns/1ps
module nv_image_model (
  // Clock
  input  wire logic       i_clk_sys,
  // Read request
  input  wire logic [8:0] i_addr,
  input  wire logic       i_rd,
  output logic      [7:0] o_data
);
  initial o_data = 8'h00;

  // Trim bytes stand in for factory values that nobody rewrites
  function automatic logic [7:0] image_byte(input logic [8:0] a);
    if (a >= 9'h080 && a <= 9'h084) begin
      return 8'hA0 | {5'h00, a[2:0]};
    end else if (a == 9'h060) begin
      return 8'h12;
    end
    return 8'h00;
  endfunction : image_byte

  // Between reads the bus wanders, so a stale byte is never trusted
  always @(posedge i_clk_sys) begin
    o_data <= i_rd ? image_byte(i_addr) : ~o_data;
  end
endmodule : nv_image_model

//--- tb/power_mode_trip_control_test.sv
// Self-checking bench for the power-mode trip control block.
// Assumes the image model as memory and a 200 MHz clock.
`timescale 1ns/1ps
`include "pmtc_defines.svh"
module power_mode_trip_control_test;
  logic        i_clk_sys         = 1'b0;
  logic        i_srst            = 1'b1;
  logic        i_cell1_above_por = 1'b0;
  logic        i_sda_in          = 1'b1;
  logic        i_scl_in          = 1'b1;
  logic [7:0]  i_reg_addr        = 8'h00;
  logic        i_reg_wr          = 1'b0;
  logic [7:0]  i_reg_wdata       = 8'h00;
  logic        i_result_valid    = 1'b0;
  logic [2:0]  i_result_sel      = 3'h0;
  logic [2:0]  i_result_res      = 3'h7;
  logic [15:0] i_result_data     = 16'h0000;
  logic        i_result_ovf      = 1'b0;
  logic [2:0]  i_sample_div      = 3'h1;
  logic [7:0]  o_reg_rdata;
  logic [8:0]  o_nv_addr;
  logic        o_nv_rd;
  logic [7:0]  i_nv_data;
  logic        o_run;
  logic        o_sample_sleep;
  logic        o_shelf_sleep;
  logic        o_conv_start;
  logic [39:0] o_cal_trim;
  logic        o_init_wr;
  logic [7:0]  o_init_addr;
  logic [7:0]  o_init_data;
  int          init_wrs  = 0;
  logic [15:0] last_init = 16'h0000;
  int          failures = 0;
  int          compares = 0;
  int          cycles   = 0;

  always #2.5 i_clk_sys = ~i_clk_sys;

  // Short sleep base keeps the interval checks to a few dozen cycles
  power_mode_trip_control #(.HALF_SEC_CYC(4)) u_power_mode_trip_control (
    .i_clk_sys, .i_srst, .i_cell1_above_por, .i_sda_in, .i_scl_in,
    .i_reg_addr, .i_reg_wr, .i_reg_wdata, .o_reg_rdata,
    .i_result_valid, .i_result_sel, .i_result_res, .i_result_data,
    .i_result_ovf, .i_sample_div, .o_nv_addr, .o_nv_rd, .i_nv_data,
    .o_init_wr, .o_init_addr, .o_init_data,
    .o_run, .o_sample_sleep, .o_shelf_sleep, .o_conv_start, .o_cal_trim
  );

  nv_image_model u_nv_image_model (
    .i_clk_sys, .i_addr(o_nv_addr), .i_rd(o_nv_rd), .o_data(i_nv_data)
  );

  // Counts image writes handed on to the other register blocks
  always @(posedge i_clk_sys) begin
    if (o_init_wr === 1'b1) begin
      init_wrs++;
      last_init = {o_init_addr, o_init_data};
    end
  end

  task automatic give_verdict;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 10000) begin
      failures++;
      give_verdict();
    end
  end

  task automatic chk_v(input logic [39:0] got, input logic [39:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_v

  task automatic chk_b(input logic got, input logic exp);
    chk_v({39'h0, got}, {39'h0, exp});
  endtask : chk_b

  task automatic step(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask : step

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_wr <= 1'b0;
  endtask : wr_reg

  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    wr_reg(a, v[7:0]);
    wr_reg(a + 8'h01, v[15:8]);
  endtask : wr16

  task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk_sys);
    i_reg_addr <= a;
    @(posedge i_clk_sys);
    #1 chk_v({32'h0, o_reg_rdata}, {32'h0, e});
  endtask : chk_reg

  task automatic send(input logic [2:0] s, input logic [2:0] r,
                      input logic [15:0] v, input logic o);
    @(posedge i_clk_sys);
    i_result_valid <= 1'b1;
    i_result_sel <= s;
    i_result_res <= r;
    i_result_data <= v;
    i_result_ovf <= o;
    @(posedge i_clk_sys);
    i_result_valid <= 1'b0;
    i_result_ovf <= 1'b0;
  endtask : send

  task automatic wait_run;
    int n;
    n = 0;
    while (o_run !== 1'b1 && n < 400) begin
      @(posedge i_clk_sys);
      #1 n++;
    end
    chk_b(o_run, 1'b1);
  endtask : wait_run

  // Supply stays low after reset release to show the hold state
  task automatic do_reset;
    @(posedge i_clk_sys);
    i_srst <= 1'b1;
    i_cell1_above_por <= 1'b0;
    i_sda_in <= 1'b1;
    i_scl_in <= 1'b1;
    step(16);
    i_srst <= 1'b0;
    step(30);
    #1 chk_b(o_run, 1'b0);
    @(posedge i_clk_sys);
    i_cell1_above_por <= 1'b1;
    wait_run();
  endtask : do_reset

  task automatic t_por;
    chk_v(o_cal_trim, 40'hA4A3A2A1A0);
    chk_reg(`A_IPOS_LO, 8'h12);
    chk_reg(`A_OPERATION_MODE_CONTROL, 8'h02);
    wr_reg(`A_OPERATION_MODE_CONTROL, 8'h02);
    chk_reg(`A_OPERATION_MODE_CONTROL, 8'h02);
    wr_reg(`A_OPERATION_MODE_CONTROL, 8'h00);
    chk_reg(`A_OPERATION_MODE_CONTROL, 8'h00);
    $display("test por done");
  endtask : t_por

  task automatic t_fields;
    wr_reg(`A_TRIPCTL, 8'hFE);
    chk_reg(`A_TRIPCTL, 8'hFC);
    wr_reg(`A_TRIPCTL, 8'h00);
    send(`SEL_CURRENT, 3'h7, 16'h7FFF, 1'b1);
    chk_reg(`A_TRIPCTL, 8'h01);
    wr_reg(`A_TRIPCTL, 8'h00);
    chk_reg(`A_TRIPCTL, 8'h00);
    wr_reg(`A_OPERATION_MODE_CONTROL, 8'h68);
    chk_reg(`A_OPERATION_MODE_CONTROL, 8'h28);
    wr_reg(`A_OPERATION_MODE_CONTROL, 8'h00);
    $display("test fields done");
  endtask : t_fields

  task automatic t_case(input logic [7:0] en, input logic [2:0] s,
                        input logic [2:0] r, input logic [15:0] v,
                        input logic st, input logic e);
    wr_reg(`A_TRIPCTL, 8'h00);
    wr_reg(`A_OPERATION_MODE_CONTROL, {st, 7'h00});
    step(2);
    #1 chk_b(o_sample_sleep, st);
    wr_reg(`A_TRIPCTL, en);
    send(s, r, v, 1'b0);
    step(2);
    #1 chk_b(o_sample_sleep, e);
  endtask : t_case

  task automatic t_trips;
    wr16(`A_IPOS_LO, 16'h0300);
    wr16(`A_INEG_LO, 16'h8200);
    wr16(`A_PACK_VOLTAGE_LO, 16'h0400);
    wr16(`A_VCELL_LO, 16'h0200);
    t_case(8'h80, `SEL_CURRENT, 3'h7, 16'h8400, 1'b1, 1'b0);
    t_case(8'h00, `SEL_CURRENT, 3'h7, 16'h0400, 1'b1, 1'b1);
    t_case(8'h40, `SEL_CURRENT, 3'h7, 16'h8100, 1'b0, 1'b1);
    t_case(8'h40, `SEL_CURRENT, 3'h7, 16'h0200, 1'b0, 1'b0);
    t_case(8'h20, `SEL_PACK, 3'h7, 16'h0500, 1'b1, 1'b0);
    t_case(8'h20, `SEL_CELL1, 3'h7, 16'h0500, 1'b1, 1'b1);
    t_case(8'h10, `SEL_CELL1, 3'h7, 16'h0100, 1'b0, 1'b1);
    t_case(8'h08, `SEL_CELL2, 3'h7, 16'h0100, 1'b0, 1'b1);
    t_case(8'h08, `SEL_CELL1, 3'h7, 16'h0100, 1'b0, 1'b0);
    t_case(8'h80, `SEL_CURRENT, 3'h0, 16'h0340, 1'b1, 1'b1);
    $display("test trips done");
  endtask : t_trips

  task automatic wait_pulse(output int n);
    n = 0;
    do begin
      @(posedge i_clk_sys);
      #1 n++;
    end while (o_conv_start !== 1'b1 && n < 300);
  endtask : wait_pulse

  task automatic t_interval;
    int n;
    wr_reg(`A_TRIPCTL, 8'h00);
    wr_reg(`A_OPERATION_MODE_CONTROL, 8'h88);
    wait_pulse(n);
    wait_pulse(n);
    chk_v({8'h00, n}, 40'd16);
    @(posedge i_clk_sys);
    i_sample_div <= 3'h0;
    wr_reg(`A_OPERATION_MODE_CONTROL, 8'h98);
    wait_pulse(n);
    wait_pulse(n);
    chk_v({8'h00, n}, 40'd32);
    wr_reg(`A_OPERATION_MODE_CONTROL, 8'h00);
    $display("test interval done");
  endtask : t_interval

  task automatic t_soft;
    wr16(`A_IPOS_LO, 16'h5555);
    init_wrs = 0;
    wr_reg(`A_OPERATION_MODE_CONTROL, 8'h01);
    step(3);
    #1 chk_b(o_run, 1'b0);
    wait_run();
    chk_v(40'(init_wrs), 40'd101);
    chk_v({24'h000000, last_init}, 40'h00000084A4);
    chk_reg(`A_IPOS_LO, 8'h12);
    chk_reg(`A_IPOS_LO + 8'h01, 8'h00);
    chk_reg(`A_OPERATION_MODE_CONTROL, 8'h00);
    $display("test soft done");
  endtask : t_soft

  // Arming alone, and a Stop with only one line low, must not sleep
  task automatic t_shelf;
    wr_reg(`A_OPERATION_MODE_CONTROL, 8'h04);
    step(20);
    #1 chk_b(o_shelf_sleep, 1'b0);
    @(posedge i_clk_sys);
    i_sda_in <= 1'b0;
    step(4);
    i_sda_in <= 1'b1;
    step(4);
    i_scl_in <= 1'b0;
    step(10);
    #1 chk_b(o_shelf_sleep, 1'b0);
    @(posedge i_clk_sys);
    i_sda_in <= 1'b0;
    step(10);
    #1 chk_b(o_shelf_sleep, 1'b1);
    $display("test shelf done");
  endtask : t_shelf

  task automatic t_store;
    wr16(`A_STORE_LO, 16'h0400);
    wr_reg(`A_TRIPCTL, 8'h04);
    send(`SEL_PACK, 3'h7, 16'h0500, 1'b0);
    step(3);
    #1 chk_b(o_shelf_sleep, 1'b0);
    send(`SEL_PACK, 3'h7, 16'h8300, 1'b0);
    step(3);
    #1 chk_b(o_shelf_sleep, 1'b1);
    $display("test store done");
  endtask : t_store

  initial begin
    do_reset();
    t_por();
    t_fields();
    t_trips();
    t_interval();
    t_soft();
    t_shelf();
    do_reset();
    t_store();
    give_verdict();
  end
endmodule : power_mode_trip_control_test
